// ==== src/fdc_cmd_map.vh ====
`ifndef FDC_CMD_MAP_VH
`define FDC_CMD_MAP_VH
// command opcodes, upper nibble
`define OP_FORCE_INT      4'hD
// type I opcodes have bit 7 clear
`define OP_TYPE1_BIT      7
// read address and read track opcodes
`define OP_READ_ADDR      4'hC
`define OP_READ_TRACK     4'hE
// condition select positions
`define CS_NR_TO_R        0
`define CS_R_TO_NR        1
`define CS_INDEX          2
`define CS_IMMEDIATE      3
// status bit positions
`define ST_BUSY           0
`define ST_NOT_READY      7
// id field length in bytes
`define ID_FIELD_LEN      3'h6
// reset values
`define STATUS_RESET      8'h00
`endif

// ==== src/id_field_mem.v ====
`timescale 1ns/100ps
// eight-entry store for the six-byte id field, registered read data
module id_field_mem
(
    // clock
    input  wire       clk,
    input  wire       ce,
    // write side
    input  wire       wr_en,
    input  wire [2:0] wr_addr,
    input  wire [7:0] wr_data,
    // read side
    input  wire [2:0] rd_addr,
    output reg  [7:0] rd_data
);
    reg [7:0] mem [0:7];

    // write and registered read
    always @(posedge clk)
    begin
        if (ce)
        begin
            if (wr_en)
                mem[wr_addr] <= wr_data;
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ==== src/floppy_cmd_interrupt_control.v ====
`timescale 1ns/100ps
`include "fdc_cmd_map.vh"
module floppy_cmd_interrupt_control
(
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    input  wire       ce,
    // host command and status
    input  wire       cmd_wr,
    input  wire [7:0] cmd_data,
    input  wire       status_rd,
    output reg  [7:0] status_out,
    // execution engine
    input  wire       exec_done,
    input  wire       exec_error,
    output reg        exec_start,
    output reg        exec_abort,
    output reg  [7:0] exec_cmd,
    // drive side
    input  wire       drive_ready,
    input  wire       index_pulse,
    input  wire       read_gate_req,
    output reg        read_gate_out,
    // disk byte stream
    input  wire       disk_byte_valid,
    input  wire [7:0] disk_byte,
    input  wire       index_mark_seen,
    // data register to host
    output reg        data_valid,
    output reg  [7:0] data_reg,
    output reg        data_sync_ok,
    // interrupt
    output reg        interrupt_request_out
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_RUN   = 2'h1;
    localparam ST_TRACK = 2'h2;
    localparam ST_ADDR  = 2'h3;

    reg  [1:0] state_r;
    reg  [1:0] state_nxt;
    reg        busy_r;
    reg        not_ready_r;
    reg        error_r;
    reg  [3:0] cond_r;
    reg        immediate_r;
    reg        ready_q_r;
    reg        synced_r;
    reg  [2:0] id_cnt_r;
    reg  [2:0] out_cnt_r;
    reg        out_pend_r;
    wire [7:0] id_rd_data;

    wire       is_force  = cmd_data[7:4] == `OP_FORCE_INT;
    wire       is_type1  = ~cmd_data[`OP_TYPE1_BIT];
    wire       force_wr  = cmd_wr && is_force;
    wire       norm_wr   = cmd_wr && !is_force;
    wire       rise_rdy  = drive_ready && !ready_q_r;
    wire       fall_rdy  = !drive_ready && ready_q_r;
    // conditions are ORed into one event
    wire       cond_hit  = (cond_r[`CS_NR_TO_R] && rise_rdy) ||
                           (cond_r[`CS_R_TO_NR] && fall_rdy) ||
                           (cond_r[`CS_INDEX] && index_pulse);
    wire       cmd_end   = busy_r && (exec_done ||
                           (state_r == ST_ADDR && out_pend_r && out_cnt_r == `ID_FIELD_LEN));
    // immediate interrupt survives everything but a zero-condition force
    wire       imm_keep  = cmd_data[`CS_IMMEDIATE] ||
                           (immediate_r && cmd_data[3:0] != 4'h0);
    // registered read: address runs one entry ahead of the output count
    wire [2:0] rd_ptr    = out_pend_r ? out_cnt_r + 3'h1 : out_cnt_r;

    // id field capture, six bytes in order
    id_field_mem u_id_mem
    (
        .clk     (clk),
        .ce      (ce),
        .wr_en   (state_r == ST_ADDR && disk_byte_valid && id_cnt_r < `ID_FIELD_LEN),
        .wr_addr (id_cnt_r),
        .wr_data (disk_byte),
        .rd_addr (rd_ptr),
        .rd_data (id_rd_data)
    );

    // next state for command sequencing
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (norm_wr && (is_type1 || drive_ready))
                begin
                    if (cmd_data[7:4] == `OP_READ_TRACK)
                        state_nxt = ST_TRACK;
                    else if (cmd_data[7:4] == `OP_READ_ADDR)
                        state_nxt = ST_ADDR;
                    else
                        state_nxt = ST_RUN;
                end
            end
            default:
            begin
                if (force_wr || cmd_end)
                    state_nxt = ST_IDLE;
            end
        endcase
    end

    // command state, busy, status and interrupt
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r               <= ST_IDLE;
            busy_r                <= 1'b0;
            not_ready_r           <= 1'b0;
            error_r               <= 1'b0;
            cond_r                <= 4'h0;
            immediate_r           <= 1'b0;
            ready_q_r             <= drive_ready; // no false edge after reset
            interrupt_request_out <= 1'b0;
            exec_start            <= 1'b0;
            exec_abort            <= 1'b0;
            exec_cmd              <= 8'h00;
            status_out            <= `STATUS_RESET;
        end
        else if (ce)
        begin
            state_r    <= state_nxt;
            ready_q_r  <= drive_ready;
            exec_start <= 1'b0;
            exec_abort <= 1'b0;
            if (force_wr)
            begin
                busy_r      <= 1'b0;
                exec_abort  <= busy_r;
                cond_r      <= cmd_data[3:0];
                immediate_r <= imm_keep;
                interrupt_request_out <= imm_keep;
            end
            else if (norm_wr)
            begin
                cond_r      <= 4'h0;
                exec_cmd    <= cmd_data;
                if (is_type1 || drive_ready)
                begin
                    busy_r      <= 1'b1;
                    not_ready_r <= 1'b0;
                    error_r     <= 1'b0;
                    exec_start  <= 1'b1;
                    interrupt_request_out <= immediate_r;
                end
                else
                begin
                    not_ready_r <= 1'b1;
                    interrupt_request_out <= 1'b1;
                end
            end
            else if (cmd_end)
            begin
                busy_r      <= 1'b0;
                error_r     <= exec_error;
                interrupt_request_out <= 1'b1;
            end
            else if (cond_hit)
                interrupt_request_out <= 1'b1;
            else if (status_rd && !immediate_r)
                interrupt_request_out <= 1'b0;
            status_out <= {not_ready_r | !drive_ready, 5'h00, error_r, busy_r};
        end
    end

    // read track stream and read address output
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            synced_r      <= 1'b0;
            id_cnt_r      <= 3'h0;
            out_cnt_r     <= 3'h0;
            out_pend_r    <= 1'b0;
            data_valid    <= 1'b0;
            data_reg      <= 8'h00;
            data_sync_ok  <= 1'b0;
            read_gate_out <= 1'b0;
        end
        else if (ce)
        begin
            data_valid    <= 1'b0;
            // read gate never actuated during read track
            read_gate_out <= read_gate_req && busy_r && state_r != ST_TRACK;
            if (state_r == ST_IDLE)
            begin
                synced_r   <= 1'b0;
                id_cnt_r   <= 3'h0;
                out_cnt_r  <= 3'h0;
                out_pend_r <= 1'b0;
            end
            else if (state_r == ST_TRACK && disk_byte_valid)
            begin
                // every byte passes, validity from the byte with the index mark on
                data_valid   <= 1'b1;
                data_reg     <= disk_byte;
                data_sync_ok <= synced_r || index_mark_seen;
                if (index_mark_seen)
                    synced_r <= 1'b1;
            end
            else if (state_r == ST_ADDR)
            begin
                if (disk_byte_valid && id_cnt_r < `ID_FIELD_LEN)
                    id_cnt_r <= id_cnt_r + 3'h1;
                // replay stored bytes once all six captured
                if (id_cnt_r == `ID_FIELD_LEN && out_cnt_r < `ID_FIELD_LEN)
                begin
                    if (out_pend_r)
                    begin
                        data_valid   <= 1'b1;
                        data_reg     <= id_rd_data;
                        data_sync_ok <= 1'b1;
                    end
                    out_pend_r <= 1'b1;
                    out_cnt_r  <= rd_ptr;
                end
            end
        end
    end
endmodule

// ==== tb/fdc_cmd_assertions.sv ====
`timescale 1ns/100ps
module fdc_cmd_assertions
(
    // watched ports
    input logic       clk,
    input logic       rst_n,
    input logic       cmd_wr,
    input logic [7:0] cmd_data,
    input logic [7:0] status_out,
    input logic       exec_done,
    input logic       exec_start,
    input logic [7:0] exec_cmd,
    input logic       drive_ready,
    input logic       read_gate_out,
    input logic       interrupt_request_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // command start, refusal and end, not ready bit, forced interrupt and read gate checks
    done_irq_a: assert property (exec_done && !cmd_wr |=> interrupt_request_out)
        else $error("no interrupt after command end");
    type1_run_a: assert property (cmd_wr && !cmd_data[7] |=> exec_start)
        else $error("type one command not started");
    nr_refuse_a: assert property (cmd_wr && cmd_data[7] && cmd_data[7:4] != 4'hD && !drive_ready
        |=> !exec_start && interrupt_request_out)
        else $error("not ready command not refused");
    nr_bit_a: assert property (!drive_ready [*3] |-> status_out[7])
        else $error("not ready bit clear");
    imm_irq_a: assert property (cmd_wr && cmd_data[7:3] == 5'h1B |=> interrupt_request_out)
        else $error("immediate interrupt missing");
    fi_idle_a: assert property (cmd_wr && cmd_data[7:4] == 4'hD ##1 !cmd_wr |=> !status_out[0])
        else $error("busy after forced interrupt");
    zero_fi_a: assert property (cmd_wr && cmd_data == 8'hD0 |=> !interrupt_request_out)
        else $error("interrupt after zero forced interrupt");
    rg_off_a: assert property (exec_cmd[7:4] == 4'hE && status_out[0] |-> !read_gate_out)
        else $error("read gate active in read track");
endmodule

// ==== tb/disk_side_model.sv ====
`timescale 1ns/100ps
// execution engine and disk stream stand-in
module disk_side_model
(
    input  logic       clk,
    input  logic       exec_start,
    input  logic       exec_abort,
    output logic       exec_done = 1'b0,
    output logic       disk_byte_valid = 1'b0,
    output logic [7:0] disk_byte = 8'h00,
    output logic       index_mark_seen = 1'b0
);
    int n = 0;
    // six id bytes A2..A7, index mark early, end at step 20
    always @(posedge clk)
    begin
        exec_done <= 1'b0;
        disk_byte_valid <= 1'b0;
        index_mark_seen <= (n == 3);
        disk_byte <= ~disk_byte; // released bus toggles
        if (exec_start) n <= 1;
        else if (exec_abort || n == 20) n <= 0;
        else if (n != 0) n <= n + 1;
        if (n > 1 && n < 8)
        begin
            disk_byte_valid <= 1'b1;
            disk_byte <= 8'hA0 + n[7:0];
        end
        if (n == 20) exec_done <= 1'b1;
    end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
    logic clk = 0, rst_n = 0, cmd_wr = 0, status_rd = 0, drive_ready = 0, index_pulse = 0;
    logic rg_req = 0, err = 0, done, abort, start, dv, bv, im, rgo, sync, irq;
    logic [7:0] cmd_data = 8'h00, st, ecmd, db, dr;
    int n_errors = 0, cmp_count = 0, cyc = 0, k;
    always #2 clk = ~clk;
    floppy_cmd_interrupt_control u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .cmd_wr(cmd_wr),
        .cmd_data(cmd_data), .status_rd(status_rd), .status_out(st), .exec_done(done),
        .exec_error(err), .exec_start(start), .exec_abort(abort), .exec_cmd(ecmd),
        .drive_ready(drive_ready), .index_pulse(index_pulse), .read_gate_req(rg_req),
        .read_gate_out(rgo), .disk_byte_valid(bv), .disk_byte(db), .index_mark_seen(im),
        .data_valid(dv), .data_reg(dr), .data_sync_ok(sync), .interrupt_request_out(irq));
    disk_side_model u_disk (.clk(clk), .exec_start(start), .exec_abort(abort), .exec_done(done),
        .disk_byte_valid(bv), .disk_byte(db), .index_mark_seen(im));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] c);
        cmd_wr <= 1'b1;
        cmd_data <= c;
        @(posedge clk) cmd_wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic rd();
        status_rd <= 1'b1;
        @(posedge clk) status_rd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // type one with drive not ready runs, ends in error, status read clears
    task automatic t_type1();
        drive_ready <= 1'b0;
        err <= 1'b1;
        wr(8'h10);
        chk(st[7], 1'h1);
        for (k = 0; k < 40 && !irq; k++) @(posedge clk);
        @(posedge clk) chk({irq, st[1], st[0]}, 3'h6);
        err <= 1'b0;
        rd();
        chk(irq, 1'h0);
    endtask
    // read address refused when not ready, six id bytes when ready
    task automatic t_raddr();
        logic [7:0] nxt_b = 8'hA2;
        int n_b = 0;
        wr(8'hC0);
        chk({irq, st[7]}, 2'h3);
        rd();
        drive_ready <= 1'b1;
        wr(8'hC0);
        for (k = 0; k < 60; k++)
        begin
            @(posedge clk);
            if (dv === 1'b1)
            begin
                chk(dr, nxt_b);
                nxt_b++;
                n_b++;
            end
        end
        chk(n_b[7:0], 8'h06);
        chk(irq, 1'h1);
        rd();
    endtask
    // read track passes all bytes, read gate low; forced stop without interrupt
    task automatic t_rtrack();
        logic [7:0] nxt_b = 8'hA2;
        int n_b = 0;
        rg_req <= 1'b1;
        wr(8'hE0);
        chk(ecmd, 8'hE0);
        for (k = 0; k < 10; k++)
        begin
            @(posedge clk) chk(rgo, 1'h0);
            if (dv === 1'b1)
            begin
                chk(dr, nxt_b);
                chk(sync, n_b > 0);
                nxt_b++;
                n_b++;
            end
        end
        chk(n_b[7:0], 8'h06);
        cmd_wr <= 1'b1;
        cmd_data <= 8'hD0;
        @(posedge clk) cmd_wr <= 1'b0;
        @(posedge clk) chk(abort, 1'h1);
        @(posedge clk) chk({irq, st[0]}, 2'h0);
        rg_req <= 1'b0;
        repeat (30) @(posedge clk);
        chk(irq, 1'h0);
    endtask
    // immediate condition sticks; index and ready conditions fire, ready-rise stays armed
    task automatic t_force();
        wr(8'hD8);
        rd();
        wr(8'h10);
        chk(irq, 1'h1);
        wr(8'hD0);
        chk(irq, 1'h0);
        // ready-fall and index selected together, no immediate
        wr(8'hD6);
        chk(irq, 1'h0);
        index_pulse <= 1'b1;
        @(posedge clk) index_pulse <= 1'b0;
        repeat (2) @(posedge clk) chk(irq, 1'h1);
        wr(8'hD6);
        chk(irq, 1'h0);
        drive_ready <= 1'b0;
        repeat (3) @(posedge clk);
        chk(irq, 1'h1);
        wr(8'hD1);
        chk(irq, 1'h0);
        drive_ready <= 1'b1;
        repeat (3) @(posedge clk);
        chk(irq, 1'h1);
        rd();
        chk(irq, 1'h0);
        drive_ready <= 1'b0;
        repeat (2) @(posedge clk);
        drive_ready <= 1'b1;
        repeat (3) @(posedge clk);
        chk(irq, 1'h1);
        rd();
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_type1();
        t_raddr();
        t_rtrack();
        t_force();
        tally_and_finish();
    end
endmodule
bind floppy_cmd_interrupt_control fdc_cmd_assertions u_chk (.clk(clk), .rst_n(rst_n),
    .cmd_wr(cmd_wr), .cmd_data(cmd_data), .status_out(status_out), .exec_done(exec_done),
    .exec_start(exec_start), .exec_cmd(exec_cmd), .drive_ready(drive_ready),
    .read_gate_out(read_gate_out), .interrupt_request_out(interrupt_request_out));
